// *** tb/ppcsr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppcsr_host_model (
   input  wire logic clk,
   input  wire logic mdio_wire,
   output logic      mdc,
   output logic      host_out,
   output logic      host_oe
);
   // Idle: clock still, line released to pull-up
   initial begin
      mdc = 1'b0;
      host_out = 1'b1;
      host_oe = 1'b0;
   end

   task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
                        input int pre, input logic [15:0] wd, output logic [16:0] rd);
      logic [31:0] body;
      body = {2'b00, op, prt, dev, 2'b10, wd};
      rd = '0;
      for (int i = pre + 31; i >= 0; i--) begin
         mdc = 1'b0;
         host_oe = !(op[1] && i < 18);
         host_out = (i > 31) ? 1'b1 : body[i];
         repeat (12) @(negedge clk);
         mdc = 1'b1;
         if (op[1] && i < 17) begin
            rd[i] = mdio_wire;
         end
         repeat (13) @(negedge clk);
      end
      mdc = 1'b0;
      host_oe = 1'b0;
      // Idle gap so the next frame starts on a later edge
      @(negedge clk);
   endtask
endmodule

`default_nettype wire

// *** tb/ppcsr_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppcsr_regs_checker #(
   parameter int unsigned RESET_HOLD = 2
) (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   mdc,
   input wire logic                   mdio_in,
   input wire logic                   mdio_out,
   input wire logic                   mdio_oe,
   input wire logic [4:0]             port_address,
   input wire logic                   fault_detect,
   input wire logic                   rx_link_up,
   input wire logic                   sublayer_reset,
   input wire ppcsr_pkg::ppcsr_rate_t speed_rate,
   input wire logic [3:0]             extended_speed_field,
   input wire logic                   power_save_request,
   input wire logic                   sublayer_loopback_enable
);
   import ppcsr_pkg::*;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // Cycles spent in sublayer reset
   int unsigned hold_cnt;
   always_ff @(posedge clk) begin
      if (reset || !sublayer_reset) begin
         hold_cnt <= 0;
      end else begin
         hold_cnt <= hold_cnt + 1;
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   a_reset_quiet: assert property (disable iff (1'b0) reset |=>
      !power_save_request && !sublayer_loopback_enable && !sublayer_reset && !mdio_oe
      && speed_rate == RATE_RESERVED) else $error("outputs active after reset");
   a_hold_count: assert property ($fell(sublayer_reset) && !$past(reset) |->
      hold_cnt == RESET_HOLD) else $error("sublayer reset length wrong");
   a_hold_bound: assert property (sublayer_reset |-> hold_cnt < RESET_HOLD)
      else $error("sublayer reset too long");
   a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround not driven low");
   a_oe_span: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
      else $error("read drive cut short");
   a_ext_ten: assert property (
      speed_rate == RATE_10G |-> extended_speed_field == EXT_10G)
      else $error("ten gig code wrong");
   a_ext_two_five: assert property (
      speed_rate == RATE_2G5 |-> extended_speed_field == EXT_2G5)
      else $error("two point five code wrong");
   a_ext_five: assert property (
      speed_rate == RATE_5G |-> extended_speed_field == EXT_5G)
      else $error("five gig code wrong");
   a_ext_other: assert property (speed_rate == RATE_OTHER |->
      extended_speed_field inside {[4'h1:4'h5]}) else $error("other rate code wrong");
   a_ext_reserved: assert property (extended_speed_field[3] |->
      speed_rate inside {RATE_RESERVED, RATE_100M, RATE_1G}) else $error("reserved code used");
endmodule

bind ppcsr_regs ppcsr_regs_checker #(.RESET_HOLD(RESET_HOLD)) u_chk (
   .clk(clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
   .mdio_oe(mdio_oe), .port_address(port_address), .fault_detect(fault_detect),
   .rx_link_up(rx_link_up), .sublayer_reset(sublayer_reset), .speed_rate(speed_rate),
   .extended_speed_field(extended_speed_field), .power_save_request(power_save_request),
   .sublayer_loopback_enable(sublayer_loopback_enable));

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import ppcsr_pkg::*;
   localparam logic [15:0] ID_HI = 16'h1357;  // Arbitrary value
   localparam logic [15:0] ID_LO = 16'h2468;  // Arbitrary value
   localparam int unsigned HOLD  = 4;
   localparam logic [4:0]  PA    = 5'h0B;
   logic        clk, reset, mdc, mdio_wire, mdio_out, mdio_oe, host_out, host_oe;
   logic        fault_detect, rx_link_up, sublayer_reset, power_save_request;
   logic        sublayer_loopback_enable;
   logic [3:0]  extended_speed_field;
   ppcsr_rate_t speed_rate;
   logic [16:0] r;
   int          fails, checks_done, held;

   // Clock and wire resolution with pull-up
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   assign mdio_wire = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);
   always @(posedge clk) if (sublayer_reset === 1'b1) held++;

   ppcsr_regs #(.ID_UPPER(ID_HI), .ID_LOWER(ID_LO), .RESET_HOLD(HOLD)) u_dut (
      .clk(clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .port_address(PA), .fault_detect(fault_detect),
      .rx_link_up(rx_link_up), .sublayer_reset(sublayer_reset), .speed_rate(speed_rate),
      .extended_speed_field(extended_speed_field), .power_save_request(power_save_request),
      .sublayer_loopback_enable(sublayer_loopback_enable));
   ppcsr_host_model u_host (.clk(clk), .mdio_wire(mdio_wire), .mdc(mdc), .host_out(host_out),
      .host_oe(host_oe));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [16:0] g, input logic [16:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic addr(input logic [15:0] off);
      u_host.frame(OP_ADDRESS, PA, DEVICE_ADDRESS, 32, off, r);
   endtask
   task automatic wr(input logic [15:0] off, input logic [15:0] d);
      addr(off);
      u_host.frame(OP_WRITE, PA, DEVICE_ADDRESS, 32, d, r);
   endtask
   task automatic rdop(input logic [1:0] op, input logic [15:0] e);
      u_host.frame(op, PA, DEVICE_ADDRESS, 32, 16'h0000, r);
      chk(r, {1'b0, e});
   endtask
   task automatic rdc(input logic [15:0] off, input logic [15:0] e);
      addr(off);
      rdop(OP_READ, e);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_reset_values;
      chk({13'h0, power_save_request, sublayer_loopback_enable, sublayer_reset, mdio_oe},
          17'h0);
      chk({14'h0, speed_rate}, {14'h0, RATE_RESERVED});
      rdc(REG_CONTROL, 16'h0000);
      rdc(REG_STATUS, 16'h0002);
      rdop(OP_READ, 16'h0006);
   endtask
   task automatic sc_ident;
      addr(REG_ID_HIGH);
      rdop(OP_READ_INCR, ID_HI);
      rdop(OP_READ_INCR, ID_LO);
      rdop(OP_READ, 16'h40B1);
   endtask
   task automatic sc_speed;
      logic [15:0] ctl [8] = '{16'h0801, 16'h2000, 16'h0040, 16'h2040,
                               16'h2058, 16'h205C, 16'h2044, 16'h2060};
      ppcsr_rate_t rate [8] = '{RATE_RESERVED, RATE_100M, RATE_1G, RATE_10G,
                                RATE_2G5, RATE_5G, RATE_OTHER, RATE_RESERVED};
      addr(REG_CONTROL);
      for (int i = 0; i < 8; i++) begin
         u_host.frame(OP_WRITE, PA, DEVICE_ADDRESS, 32, ctl[i], r);
         chk({14'h0, speed_rate}, {14'h0, rate[i]});
         chk({13'h0, extended_speed_field}, {13'h0, ctl[i][5:2]});
         chk({15'h0, power_save_request, sublayer_loopback_enable},
             {15'h0, ctl[i][11], ctl[i][0]});
      end
      rdop(OP_READ, 16'h2060);
      u_host.frame(OP_WRITE, PA, DEVICE_ADDRESS, 32, r[15:0] | 16'h0800, r);
      chk({16'h0, power_save_request}, 17'h1);
   endtask
   task automatic sc_soft_reset;
      held = 0;
      wr(REG_CONTROL, 16'h8801);
      chk(17'(held), 17'(HOLD));
      rdc(REG_CONTROL, 16'h0801);
   endtask
   task automatic sc_status;
      fault_detect = 1'b1;
      rdc(REG_STATUS, 16'h0086);
      rx_link_up = 1'b0;
      repeat (2) @(negedge clk);
      rx_link_up = 1'b1;
      rdop(OP_READ, 16'h0082);
      fault_detect = 1'b0;
      rdop(OP_READ, 16'h0006);
   endtask
   task automatic sc_refuse;
      addr(REG_CONTROL);
      u_host.frame(OP_WRITE, PA, DEVICE_ADDRESS, 31, 16'h2040, r);
      u_host.frame(OP_WRITE, PA ^ 5'h01, DEVICE_ADDRESS, 32, 16'h2040, r);
      u_host.frame(OP_WRITE, PA, 5'h03, 32, 16'h2040, r);
      rdop(OP_READ, 16'h0801);
      u_host.frame(OP_READ, PA ^ 5'h01, DEVICE_ADDRESS, 32, 16'h0000, r);
      chk(r, 17'h1FFFF);
      wr(REG_ABILITY, 16'h0000);
      rdc(REG_ABILITY, 16'h40B1);
      rdc(16'h8000, 16'h0000);
      rdc(16'h0005, 16'h0000);
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (95000) @(posedge clk);
      fails++;
      wrap_up;
   end

   initial begin
      reset = 1'b1;
      fault_detect = 1'b0;
      rx_link_up = 1'b1;
      fails = 0;
      checks_done = 0;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      sc_reset_values;
      sc_ident;
      sc_speed;
      sc_soft_reset;
      sc_status;
      sc_refuse;
      wrap_up;
   end
endmodule

`default_nettype wire

// *** verilog/ppcsr_link_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppcsr_link_sampler (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic mdc,
   input  wire logic mdio_in,
   output logic      mdio_sync,
   output logic      mdc_rise
);

   logic mdc_meta;
   logic mdc_sync;
   logic mdc_last;
   logic mdio_meta;

   // ****************************************
   // Two-stage synchronisers
   // ****************************************

   // Clock and data pass the same depth so they stay aligned
   always_ff @(posedge clk) begin
      if (reset) begin
         mdc_meta  <= 1'b0;
         mdc_sync  <= 1'b0;
         mdio_meta <= 1'b1;
         mdio_sync <= 1'b1;
      end else begin
         mdc_meta  <= mdc;
         mdc_sync  <= mdc_meta;
         mdio_meta <= mdio_in;
         mdio_sync <= mdio_meta;
      end
   end

   // ****************************************
   // Rising edge of the management clock
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         mdc_last <= 1'b0;
         mdc_rise <= 1'b0;
      end else begin
         mdc_last <= mdc_sync;
         mdc_rise <= mdc_sync & ~mdc_last;
      end
   end

endmodule

`default_nettype wire

// *** verilog/ppcsr_pkg.sv ***
package ppcsr_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned RESET_TIME_NS = 100;
   localparam int unsigned RESET_CYCLES  =
      (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // Frame layout
   // ****************************************
   localparam logic [4:0] DEVICE_ADDRESS = 5'h01;
   localparam logic [5:0] PREAMBLE_ONES  = 6'h20;
   localparam logic [3:0] HEADER_LAST    = 4'hB;
   localparam logic [3:0] DATA_LAST      = 4'hF;
   localparam logic [1:0] OP_ADDRESS     = 2'h0;
   localparam logic [1:0] OP_WRITE       = 2'h1;
   localparam logic [1:0] OP_READ_INCR   = 2'h2;
   localparam logic [1:0] OP_READ        = 2'h3;
   localparam int unsigned ADDR_VENDOR_BIT = 15;

   // ****************************************
   // Register offsets and reset values
   // ****************************************
   localparam logic [15:0] REG_CONTROL   = 16'h0000;
   localparam logic [15:0] REG_STATUS    = 16'h0001;
   localparam logic [15:0] REG_ID_HIGH   = 16'h0002;
   localparam logic [15:0] REG_ID_LOW    = 16'h0003;
   localparam logic [15:0] REG_ABILITY   = 16'h0004;
   localparam logic [14:0] CONTROL_RESET = 15'h0000;
   localparam logic [15:0] ADDRESS_RESET = 16'h0000;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned CTL_RESET_BIT    = 15;
   localparam int unsigned CTL_SPEED_A_BIT  = 13;
   localparam int unsigned CTL_POWER_BIT    = 11;
   localparam int unsigned CTL_SPEED_B_BIT  = 6;
   localparam int unsigned CTL_EXT_LSB      = 2;
   localparam int unsigned CTL_LOOP_BIT     = 0;
   localparam int unsigned STS_FAULT_BIT    = 7;
   localparam int unsigned STS_LINK_BIT     = 2;
   localparam int unsigned STS_POWER_BIT    = 1;
   localparam int unsigned ABL_EXT_RATES    = 14;
   localparam int unsigned ABL_TWO_FIVE     = 13;
   localparam int unsigned ABL_FORTY_HUND   = 10;
   localparam int unsigned ABL_MULTIPOINT   = 9;
   localparam int unsigned ABL_FAST_TX      = 7;
   localparam int unsigned ABL_BACKPLANE_KX = 6;
   localparam int unsigned ABL_HUNDRED_MEG  = 5;
   localparam int unsigned ABL_GIGABIT      = 4;
   localparam int unsigned ABL_PASS_TS      = 2;
   localparam int unsigned ABL_BASE_TL      = 1;
   localparam int unsigned ABL_TEN_GIG      = 0;

   // ****************************************
   // Speed codes
   // ****************************************
   localparam logic [3:0] EXT_10G = 4'h0;
   localparam logic [3:0] EXT_2G5 = 4'h6;
   localparam logic [3:0] EXT_5G  = 4'h7;

   typedef enum logic [2:0] {
      RATE_RESERVED,
      RATE_100M,
      RATE_1G,
      RATE_10G,
      RATE_2G5,
      RATE_5G,
      RATE_OTHER
   } ppcsr_rate_t;

   typedef enum logic [2:0] {
      ST_PREAMBLE,
      ST_START,
      ST_HEADER,
      ST_TURN,
      ST_DATA
   } ppcsr_frame_t;

endpackage

// *** verilog/ppcsr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppcsr_regs #(
   parameter logic [15:0] ID_UPPER   = 16'hA5C3,  // Arbitrary value
   parameter logic [15:0] ID_LOWER   = 16'h0C10,  // Arbitrary value, revision dependent
   parameter int unsigned RESET_HOLD = ppcsr_pkg::RESET_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               mdc,
   input  wire logic               mdio_in,
   output logic                    mdio_out,
   output logic                    mdio_oe,
   input  wire logic [4:0]         port_address,
   input  wire logic               fault_detect,
   input  wire logic               rx_link_up,
   output logic                    sublayer_reset,
   output ppcsr_pkg::ppcsr_rate_t  speed_rate,
   output logic [3:0]              extended_speed_field,
   output logic                    power_save_request,
   output logic                    sublayer_loopback_enable
);
   import ppcsr_pkg::*;

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (RESET_HOLD < 1 || RESET_HOLD > 65535) begin : g_bad_hold
      $error("RESET_HOLD out of range");
   end

   // ****************************************
   // Declarations
   // ****************************************
   logic         mdio_sync;
   logic         mdc_rise;
   logic [4:0]   strap_meta;
   logic [4:0]   strap_sync;
   logic [4:0]   own_port;
   ppcsr_frame_t frame_state;
   logic [5:0]   ones_count;
   logic [3:0]   bit_count;
   logic [11:0]  header;
   logic [11:0]  next_header;
   logic [15:0]  shift_in;
   logic [15:0]  shift_out;
   logic [15:0]  next_word;
   logic [1:0]   frame_op;
   logic         frame_ours;
   logic         frame_read;
   logic         take_read;
   logic         commit;
   logic         ieee_space;
   logic [15:0]  addr_reg;
   logic [14:0]  control_store;
   logic [15:0]  reset_count;
   logic         link_latched;
   logic [15:0]  ability;
   logic [15:0]  read_word;

   // Offset match inside the IEEE register space
   function automatic logic reg_hit(input logic [15:0] addr,
                                    input logic [15:0] offset);
      reg_hit = (addr[ADDR_VENDOR_BIT] == 1'b0) && (addr == offset);
   endfunction

   // Rate chosen by the two select bits and the extended field
   function automatic ppcsr_rate_t decode_rate(input logic [14:0] ctl);
      logic [3:0] ext;
      ext = ctl[CTL_EXT_LSB +: 4];
      case ({ctl[CTL_SPEED_B_BIT], ctl[CTL_SPEED_A_BIT]})
         2'b11: begin
            if (ext[3]) begin
               decode_rate = RATE_RESERVED;
            end else if (ext == EXT_10G) begin
               decode_rate = RATE_10G;
            end else if (ext == EXT_2G5) begin
               decode_rate = RATE_2G5;
            end else if (ext == EXT_5G) begin
               decode_rate = RATE_5G;
            end else begin
               decode_rate = RATE_OTHER;
            end
         end
         2'b10:   decode_rate = RATE_1G;
         2'b01:   decode_rate = RATE_100M;
         default: decode_rate = RATE_RESERVED;
      endcase
   endfunction

   // ****************************************
   // Management line sampling
   // ****************************************
   ppcsr_link_sampler u_sampler (
      .clk       (clk),
      .reset     (reset),
      .mdc       (mdc),
      .mdio_in   (mdio_in),
      .mdio_sync (mdio_sync),
      .mdc_rise  (mdc_rise)
   );

   // Port strap synchronised, then caught while reset is held
   always_ff @(posedge clk) begin
      strap_meta <= port_address;
      strap_sync <= strap_meta;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         own_port <= strap_sync;
      end
   end

   // ****************************************
   // Frame decode
   // ****************************************

   // Header and data words including the bit now sampled
   assign next_header = {header[10:0], mdio_sync};
   assign next_word   = {shift_in[14:0], mdio_sync};
   assign frame_op    = header[11:10];
   assign ieee_space  = ~addr_reg[ADDR_VENDOR_BIT];

   // read data fetched at first turnaround bit
   assign take_read = mdc_rise && frame_state == ST_TURN && bit_count == 4'h0
                      && frame_ours && frame_read;
   // last data bit of an addressed frame
   assign commit    = mdc_rise && frame_state == ST_DATA && bit_count == DATA_LAST
                      && frame_ours;

   // Frame state machine, one step per management clock rising edge
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_state <= ST_PREAMBLE;
         ones_count  <= 6'h00;
         bit_count   <= 4'h0;
         header      <= 12'h000;
         shift_in    <= 16'h0000;
         frame_ours  <= 1'b0;
         frame_read  <= 1'b0;
      end else if (mdc_rise) begin
         case (frame_state)
            ST_PREAMBLE: begin
               if (mdio_sync) begin
                  if (ones_count != PREAMBLE_ONES) begin
                     ones_count <= ones_count + 6'h01;
                  end
               end else begin
                  ones_count <= 6'h00;
                  if (ones_count == PREAMBLE_ONES) begin
                     frame_state <= ST_START;
                  end
               end
            end
            ST_START: begin
               bit_count <= 4'h0;
               if (mdio_sync) begin
                  frame_state <= ST_PREAMBLE;
                  ones_count  <= 6'h01;
               end else begin
                  frame_state <= ST_HEADER;
               end
            end
            ST_HEADER: begin
               header    <= next_header;
               bit_count <= bit_count + 4'h1;
               if (bit_count == HEADER_LAST) begin
                  // port and device 1 must match
                  frame_ours  <= (next_header[9:5] == own_port)
                                 && (next_header[4:0] == DEVICE_ADDRESS);
                  frame_read  <= next_header[11];
                  frame_state <= ST_TURN;
                  bit_count   <= 4'h0;
               end
            end
            ST_TURN: begin
               bit_count <= bit_count + 4'h1;
               if (bit_count == 4'h1) begin
                  frame_state <= ST_DATA;
                  bit_count   <= 4'h0;
               end
            end
            ST_DATA: begin
               shift_in  <= next_word;
               bit_count <= bit_count + 4'h1;
               if (bit_count == DATA_LAST) begin
                  frame_state <= ST_PREAMBLE;
                  ones_count  <= 6'h00;
                  frame_ours  <= 1'b0;
                  frame_read  <= 1'b0;
               end
            end
            default: begin
               frame_state <= ST_PREAMBLE;
               ones_count  <= 6'h00;
            end
         endcase
      end
   end

   // ****************************************
   // Read driver
   // ****************************************

   // Turnaround zero, then data MSB first after each rising edge
   always_ff @(posedge clk) begin
      if (reset) begin
         mdio_out  <= 1'b0;
         mdio_oe   <= 1'b0;
         shift_out <= 16'h0000;
      end else if (take_read) begin
         mdio_oe   <= 1'b1;
         mdio_out  <= 1'b0;
         shift_out <= read_word;
      end else if (mdc_rise && mdio_oe) begin
         if (frame_state == ST_DATA && bit_count == DATA_LAST) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
         end else begin
            mdio_out  <= shift_out[15];
            shift_out <= {shift_out[14:0], 1'b0};
         end
      end
   end

   // ****************************************
   // Address register
   // ****************************************

   // address frame loads offset, read-increment advances
   always_ff @(posedge clk) begin
      if (reset) begin
         addr_reg <= ADDRESS_RESET;
      end else if (commit) begin
         if (frame_op == OP_ADDRESS) begin
            addr_reg <= next_word;
         end else if (frame_op == OP_READ_INCR) begin
            addr_reg <= addr_reg + 16'h0001;
         end
      end
   end

   // ****************************************
   // Control register
   // ****************************************

   // Reserved bits are stored so read-modify-write returns them
   always_ff @(posedge clk) begin
      if (reset) begin
         control_store <= CONTROL_RESET;
      end else if (commit && frame_op == OP_WRITE && reg_hit(addr_reg, REG_CONTROL)) begin
         control_store <= next_word[14:0];
      end
   end

   // Self-clearing sublayer reset, timed in system clocks
   always_ff @(posedge clk) begin
      if (reset) begin
         reset_count    <= 16'h0000;
         sublayer_reset <= 1'b0;
      end else if (commit && frame_op == OP_WRITE && reg_hit(addr_reg, REG_CONTROL)
                   && next_word[CTL_RESET_BIT]) begin
         reset_count    <= RESET_HOLD[15:0];
         sublayer_reset <= 1'b1;
      end else if (reset_count != 16'h0000) begin
         reset_count    <= reset_count - 16'h0001;
         sublayer_reset <= (reset_count != 16'h0001);
      end
   end

   // Control outputs follow the stored bits
   always_ff @(posedge clk) begin
      if (reset) begin
         speed_rate               <= RATE_RESERVED;
         extended_speed_field     <= 4'h0;
         power_save_request       <= 1'b0;
         sublayer_loopback_enable <= 1'b0;
      end else begin
         speed_rate               <= decode_rate(control_store);
         extended_speed_field     <= control_store[CTL_EXT_LSB +: 4];
         power_save_request       <= control_store[CTL_POWER_BIT];
         sublayer_loopback_enable <= control_store[CTL_LOOP_BIT];
      end
   end

   // ****************************************
   // Status register
   // ****************************************

   // Link drop wins over the reload done by a status read
   always_ff @(posedge clk) begin
      if (reset) begin
         link_latched <= 1'b0;
      end else if (!rx_link_up) begin
         link_latched <= 1'b0;
      end else if (take_read && reg_hit(addr_reg, REG_STATUS)) begin
         link_latched <= 1'b1;
      end
   end

   // ****************************************
   // Ability word
   // ****************************************
   always_comb begin
      ability = 16'h0000;
      ability[ABL_EXT_RATES]    = 1'b1;
      ability[ABL_TWO_FIVE]     = 1'b0;
      ability[ABL_FORTY_HUND]   = 1'b0;
      ability[ABL_MULTIPOINT]   = 1'b0;
      ability[ABL_FAST_TX]      = 1'b1;
      ability[ABL_BACKPLANE_KX] = 1'b0;
      ability[ABL_HUNDRED_MEG]  = 1'b1;
      ability[ABL_GIGABIT]      = 1'b1;
      ability[ABL_TEN_GIG]      = 1'b1;
      ability[ABL_PASS_TS]      = 1'b0;
      ability[ABL_BASE_TL]      = 1'b0;
   end

   // ****************************************
   // Read multiplexer
   // ****************************************

   // Unmapped and vendor-space offsets read as zero
   always_comb begin
      read_word = 16'h0000;
      if (ieee_space) begin
         case (addr_reg)
            REG_CONTROL: begin
               read_word = {sublayer_reset, control_store};
            end
            REG_STATUS: begin
               read_word[STS_FAULT_BIT] = fault_detect;
               read_word[STS_LINK_BIT]  = link_latched;
               read_word[STS_POWER_BIT] = 1'b1;
            end
            REG_ID_HIGH: read_word = ID_UPPER;
            REG_ID_LOW:  read_word = ID_LOWER;
            REG_ABILITY: read_word = ability;
            default:     read_word = 16'h0000;
         endcase
      end
   end

endmodule

`default_nettype wire
